// ==== design/dcob_defines.svh ====
// Object indices, field positions, reset values and timing counts for the drive object bank
`ifndef DCOB_DEFINES_SVH
`define DCOB_DEFINES_SVH

// Object-dictionary indices
`define DCOB_IDX_SLIPPAGE_TIMEOUT 16'h203f
`define DCOB_IDX_PULSE_MULTIPLIER 16'h2057
`define DCOB_IDX_PULSE_DIVIDER 16'h2058
`define DCOB_IDX_ENCODER_TYPE 16'h2059
`define DCOB_IDX_ABS_BOOT_POS 16'h205a
`define DCOB_IDX_PULSE_MODE 16'h205b
`define DCOB_IDX_BOOT_DELAY 16'h2084
`define DCOB_IDX_FB_AVAIL 16'h2101
`define DCOB_IDX_FB_CONTROL 16'h2102
`define DCOB_IDX_FB_STATUS 16'h2103

// Subindices of the status array
`define DCOB_SUB_COUNT 8'h00
`define DCOB_SUB_DISABLE_MASK 8'h01
`define DCOB_SUB_ENABLED 8'h02
`define DCOB_FB_STATUS_ENTRIES 32'h00000002

// Reset values
`define DCOB_RST_SLIPPAGE_TIMEOUT 16'h0064
`define DCOB_RST_MULTIPLIER 32'h00000080
`define DCOB_RST_DIVIDER 32'h00000001
`define DCOB_RST_ENCODER_TYPE 32'h00000000
`define DCOB_RST_PULSE_MODE 32'h00000000
`define DCOB_RST_BOOT_DELAY 32'h00000000
`define DCOB_RST_FB_AVAIL 32'h001d0011
`define DCOB_RST_FB_CONTROL 32'h001d0011
`define DCOB_RST_FB_DISABLE_MASK 32'h00000000

// Field positions
`define DCOB_BIT_ENCODER_TYPE 0
`define DCOB_BIT_PULSE_MODE 0
`define DCOB_BIT_STATUS_SLIPPAGE 13
`define DCOB_FB_IF_LSB 0
`define DCOB_FB_IF_MSB 15
`define DCOB_FB_PROTO_LSB 16
`define DCOB_FB_PROTO_MSB 31
`define DCOB_FB_USB 0
`define DCOB_FB_RS485 1
`define DCOB_FB_RS232 2
`define DCOB_FB_CAN 3
`define DCOB_FB_PLAIN_ETHERNET_PORT 4
`define DCOB_FB_REALTIME_ETHERNET_B_PORT 5
`define DCOB_FB_SPI 6
`define DCOB_FB_SERIAL_MODBUS_PROTOCOL 16
`define DCOB_FB_NETWORKED_MODBUS_PROTOCOL 17
`define DCOB_FB_INDUSTRIAL_ETHERNET_PROTOCOL 18

// Timing: one millisecond at the system clock
`define DCOB_CLOCK_HZ 100000000
`define DCOB_MS_TIME_US 1000
`define DCOB_CYCLES_PER_MS ((`DCOB_CLOCK_HZ / 1000000) * `DCOB_MS_TIME_US)

`endif

// ==== design/dcob_pkg.sv ====
// Types shared by the drive object bank and its users
package dcob_pkg;

    // Object access request from the fieldbus host
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } dcob_req_type;

    // Object access answer, one cycle after the request
    typedef struct packed {
        logic valid;
        logic error;
        logic [31:0] rdata;
    } dcob_rsp_type;

    // Slippage supervisor states
    typedef enum logic [2:0] {
        SLIP_IDLE = 3'b001,
        SLIP_TIMING = 3'b010,
        SLIP_FLAGGED = 3'b100
    } dcob_slip_state_type;

endpackage : dcob_pkg

// ==== design/dcob_bank.sv ====
// Drive configuration and status object bank
//
// Function
// - In velocity profile mode statusword bit 13 is set when speed error exceeds max slippage.
// - The slippage flag rises only after the excess has lasted longer than the timeout object.
// - The slippage timeout counts in milliseconds.
// - With a slippage reaction configured, a slippage error also pushes an error-history entry.
// - In step/direction mode the pulse count is multiplied by the signed multiplier object.
// - In step/direction mode the pulse count is divided by the signed divider object.
// - Encoder type bit 0 selects differential (0) or single-ended (1) encoder input.
// - The absolute position is captured at power-on, and reads 0 without an absolute encoder.
// - Pulse mode value 0 selects step/direction and value 1 selects cw/ccw pulse input.
// - After power-on the drive waits the boot-up delay in milliseconds before being ready.
// - Fieldbus bitmap bits 0 to 15 are interfaces and bits 16 to 31 are protocols.
// - Each availability bit reads 1 when that interface or protocol is present.
// - Bit positions are fixed for each interface (bits 0 to 6) and protocol (bits 16 to 18).
// - The control bitmap switches only those fieldbuses that the disable mask allows.
// - The status object reports every active fieldbus as 1 in the control bit layout.
// - A disable-mask bit reads 1 when that fieldbus can be switched off.
`include "dcob_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dcob_bank #(
    parameter int unsigned MS_CYCLES = `DCOB_CYCLES_PER_MS,
    parameter logic [31:0] FB_AVAILABLE = `DCOB_RST_FB_AVAIL,
    parameter logic [31:0] FB_DISABLE_MASK = `DCOB_RST_FB_DISABLE_MASK
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Object access
    input wire dcob_pkg::dcob_req_type req,
    output var dcob_pkg::dcob_rsp_type rsp,
    // Speed supervision
    input wire logic velocity_mode,
    input wire logic signed [31:0] actual_speed,
    input wire logic signed [31:0] commanded_speed,
    input wire logic [31:0] max_slippage,
    input wire logic slip_reaction_enabled,
    output logic statusword_slip,
    output logic error_history_push,
    // Pulse input
    input wire logic step_pulse,
    input wire logic step_direction,
    input wire logic cw_pulse,
    input wire logic ccw_pulse,
    output logic signed [31:0] scaled_pulse_count,
    output logic pulse_mode_cwccw,
    // Encoder and boot
    input wire logic abs_encoder_present,
    input wire logic signed [31:0] abs_encoder_position,
    output logic encoder_single_ended,
    output logic drive_ready,
    // Fieldbus
    output logic [31:0] fieldbus_active
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Magnitude of a speed difference, never overflows
    function automatic logic [32:0] dcob_abs_diff(input logic signed [31:0] a,
                                                  input logic signed [31:0] b);
        logic signed [32:0] d;
        d = 33'(a) - 33'(b);
        dcob_abs_diff = d[32] ? 33'(-d) : 33'(d);
    endfunction : dcob_abs_diff

    // Count times multiplier over divider; divider of zero holds the old value
    function automatic logic signed [31:0] dcob_scale(input logic signed [31:0] count,
                                                      input logic signed [31:0] mul,
                                                      input logic signed [31:0] div,
                                                      input logic signed [31:0] hold);
        logic signed [63:0] prod;
        logic signed [63:0] quot;
        prod = 64'(count) * 64'(mul);
        quot = (div == 32'sh0) ? 64'(hold) : prod / 64'(div);
        dcob_scale = quot[31:0];
    endfunction : dcob_scale

    ////////////////////////////////////////////////////////////////////////////////
    // Objects

    logic [15:0] slippage_timeout;
    logic signed [31:0] pulse_count_multiplier;
    logic signed [31:0] pulse_count_divider;
    logic [31:0] encoder_type_config;
    logic signed [31:0] absolute_position_at_boot;
    logic [31:0] pulse_input_mode_select;
    logic [31:0] boot_up_delay;
    logic [31:0] fieldbus_enable_control;
    logic [31:0] fieldbus_availability;
    logic [31:0] fieldbus_disable_mask;

    logic req_sub0;
    logic wr_ok;

    // Presence and switchability are build options of the device
    assign fieldbus_availability = FB_AVAILABLE;
    assign fieldbus_disable_mask = FB_DISABLE_MASK & FB_AVAILABLE;
    assign req_sub0 = (req.subindex == 8'h00);
    assign wr_ok = req.wr && req_sub0;

    // Host writes to the read/write objects
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            slippage_timeout <= `DCOB_RST_SLIPPAGE_TIMEOUT;
            pulse_count_multiplier <= `DCOB_RST_MULTIPLIER;
            pulse_count_divider <= `DCOB_RST_DIVIDER;
            encoder_type_config <= `DCOB_RST_ENCODER_TYPE;
            pulse_input_mode_select <= `DCOB_RST_PULSE_MODE;
            boot_up_delay <= `DCOB_RST_BOOT_DELAY;
            fieldbus_enable_control <= `DCOB_RST_FB_CONTROL;
        end else if (wr_ok) begin
            unique case (req.index)
                `DCOB_IDX_SLIPPAGE_TIMEOUT: slippage_timeout <= req.wdata[15:0];
                `DCOB_IDX_PULSE_MULTIPLIER: pulse_count_multiplier <= req.wdata;
                `DCOB_IDX_PULSE_DIVIDER: pulse_count_divider <= req.wdata;
                `DCOB_IDX_ENCODER_TYPE: encoder_type_config <= req.wdata;
                `DCOB_IDX_PULSE_MODE: pulse_input_mode_select <= req.wdata;
                `DCOB_IDX_BOOT_DELAY: boot_up_delay <= req.wdata;
                `DCOB_IDX_FB_CONTROL: fieldbus_enable_control <= req.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Object reads and answers

    logic [31:0] next_rdata;
    logic next_error;

    // Read decode; writes to read-only or unknown objects are refused
    always_comb begin
        next_rdata = 32'h00000000;
        next_error = 1'b0;
        if (req.index == `DCOB_IDX_FB_STATUS) begin
            unique case (req.subindex)
                `DCOB_SUB_COUNT: next_rdata = `DCOB_FB_STATUS_ENTRIES;
                `DCOB_SUB_DISABLE_MASK: next_rdata = fieldbus_disable_mask;
                `DCOB_SUB_ENABLED: next_rdata = fieldbus_active;
                default: next_error = 1'b1;
            endcase
            next_error = next_error | req.wr;
        end else if (!req_sub0) begin
            next_error = 1'b1;
        end else begin
            unique case (req.index)
                `DCOB_IDX_SLIPPAGE_TIMEOUT: next_rdata = {16'h0000, slippage_timeout};
                `DCOB_IDX_PULSE_MULTIPLIER: next_rdata = pulse_count_multiplier;
                `DCOB_IDX_PULSE_DIVIDER: next_rdata = pulse_count_divider;
                `DCOB_IDX_ENCODER_TYPE: next_rdata = encoder_type_config;
                `DCOB_IDX_ABS_BOOT_POS: begin
                    next_rdata = absolute_position_at_boot;
                    next_error = req.wr;
                end
                `DCOB_IDX_PULSE_MODE: next_rdata = pulse_input_mode_select;
                `DCOB_IDX_BOOT_DELAY: next_rdata = boot_up_delay;
                `DCOB_IDX_FB_AVAIL: begin
                    next_rdata = fieldbus_availability;
                    next_error = req.wr;
                end
                `DCOB_IDX_FB_CONTROL: next_rdata = fieldbus_enable_control;
                default: next_error = 1'b1;
            endcase
        end
    end

    // Answer one cycle after each request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.wr | req.rd;
            rsp.error <= (req.wr | req.rd) & next_error;
            rsp.rdata <= req.rd ? next_rdata : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond tick

    logic [16:0] tick_count;
    logic ms_tick;

    // Shared millisecond base; all ms objects count on the same tick
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_count <= 17'h00000;
            ms_tick <= 1'b0;
        end else if (tick_count == 17'(MS_CYCLES - 1)) begin
            tick_count <= 17'h00000;
            ms_tick <= 1'b1;
        end else begin
            tick_count <= tick_count + 17'h00001;
            ms_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slippage supervision

    dcob_pkg::dcob_slip_state_type slip_state;
    logic [16:0] slip_ms;
    logic excess;

    assign excess = velocity_mode &&
                    (dcob_abs_diff(actual_speed, commanded_speed) > {1'b0, max_slippage});

    // Excess must persist longer than the timeout before the flag rises
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            slip_state <= dcob_pkg::SLIP_IDLE;
            slip_ms <= 17'h00000;
        end else if (!excess) begin
            slip_state <= dcob_pkg::SLIP_IDLE;
            slip_ms <= 17'h00000;
        end else begin
            unique case (slip_state)
                dcob_pkg::SLIP_IDLE: slip_state <= dcob_pkg::SLIP_TIMING;
                dcob_pkg::SLIP_TIMING: begin
                    if (ms_tick) begin
                        slip_ms <= slip_ms + 17'h00001;
                    end
                    if (slip_ms > {1'b0, slippage_timeout}) begin
                        slip_state <= dcob_pkg::SLIP_FLAGGED;
                    end
                end
                dcob_pkg::SLIP_FLAGGED: ;
            endcase
        end
    end

    // Statusword bit and history entry; the push fires once per new error
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            statusword_slip <= 1'b0;
            error_history_push <= 1'b0;
        end else begin
            statusword_slip <= excess && (slip_state == dcob_pkg::SLIP_FLAGGED);
            error_history_push <= excess && slip_reaction_enabled && !statusword_slip &&
                                  (slip_state == dcob_pkg::SLIP_FLAGGED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse input and scaling

    logic step_prev;
    logic cw_prev;
    logic ccw_prev;
    logic signed [31:0] pulse_count;
    logic signed [31:0] next_pulse_count;

    // Count rising edges in the selected pulse mode
    always_comb begin
        next_pulse_count = pulse_count;
        if (!pulse_input_mode_select[`DCOB_BIT_PULSE_MODE]) begin
            if (step_pulse && !step_prev) begin
                next_pulse_count = step_direction ? pulse_count - 32'sd1 : pulse_count + 32'sd1;
            end
        end else begin
            if (cw_pulse && !cw_prev && !(ccw_pulse && !ccw_prev)) begin
                next_pulse_count = pulse_count + 32'sd1;
            end else if (ccw_pulse && !ccw_prev && !(cw_pulse && !cw_prev)) begin
                next_pulse_count = pulse_count - 32'sd1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            step_prev <= 1'b0;
            cw_prev <= 1'b0;
            ccw_prev <= 1'b0;
            pulse_count <= 32'sh0;
        end else begin
            step_prev <= step_pulse;
            cw_prev <= cw_pulse;
            ccw_prev <= ccw_pulse;
            pulse_count <= next_pulse_count;
        end
    end

    // Scaled count; a full 64-bit product keeps large ratios exact, at a cost in area
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scaled_pulse_count <= 32'sh0;
        end else begin
            scaled_pulse_count <= dcob_scale(pulse_count, pulse_count_multiplier,
                                             pulse_count_divider, scaled_pulse_count);
        end
    end

    // Mode and encoder selections driven from flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pulse_mode_cwccw <= 1'b0;
            encoder_single_ended <= 1'b0;
        end else begin
            pulse_mode_cwccw <= pulse_input_mode_select[`DCOB_BIT_PULSE_MODE];
            encoder_single_ended <= encoder_type_config[`DCOB_BIT_ENCODER_TYPE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-on capture and boot-up delay

    logic boot_captured;
    logic [31:0] boot_ms;

    // Position caught on the first edge after reset release, never under reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            boot_captured <= 1'b0;
            absolute_position_at_boot <= 32'sh0;
        end else if (!boot_captured) begin
            boot_captured <= 1'b1;
            absolute_position_at_boot <= abs_encoder_present ? abs_encoder_position : 32'sh0;
        end
    end

    // Ready once the elapsed milliseconds reach the delay; counter saturates
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            boot_ms <= 32'h00000000;
            drive_ready <= 1'b0;
        end else begin
            if (ms_tick && (boot_ms != 32'hffffffff)) begin
                boot_ms <= boot_ms + 32'h00000001;
            end
            if (boot_ms >= boot_up_delay) begin
                drive_ready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fieldbus active set

    // Unswitchable present buses stay on; switchable ones follow control
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fieldbus_active <= FB_AVAILABLE;
        end else begin
            fieldbus_active <= (fieldbus_availability & ~fieldbus_disable_mask) |
                               (fieldbus_enable_control & fieldbus_disable_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_slip_mode_off: assert property (@(posedge clock) disable iff (!resetn)
        !velocity_mode |=> !statusword_slip)
        else $error("slippage flag set outside velocity mode");

    chk_slip_persist: assert property (@(posedge clock) disable iff (!resetn)
        $rose(statusword_slip) |-> $past(slip_ms, 2) > {1'b0, $past(slippage_timeout, 2)})
        else $error("slippage flag rose before timeout expired");

    chk_slip_ms_step: assert property (@(posedge clock) disable iff (!resetn)
        (slip_ms != $past(slip_ms)) && (slip_ms != 17'h00000) |-> $past(ms_tick))
        else $error("slippage timer advanced without a millisecond tick");

    chk_history_push: assert property (@(posedge clock) disable iff (!resetn)
        error_history_push |-> statusword_slip && $past(slip_reaction_enabled)
                               && !$past(statusword_slip))
        else $error("history entry without new configured slippage error");

    chk_scale_ratio: assert property (@(posedge clock) disable iff (!resetn)
        $stable(pulse_count) && $stable(pulse_count_multiplier) && (pulse_count_divider == 32'sd1)
        |=> scaled_pulse_count == 32'($past(pulse_count) * $past(pulse_count_multiplier)))
        else $error("scaled count does not match multiplier");

    chk_encoder_type: assert property (@(posedge clock) disable iff (!resetn)
        ##1 encoder_single_ended == $past(encoder_type_config[`DCOB_BIT_ENCODER_TYPE]))
        else $error("encoder type output does not follow its object");

    chk_boot_zero: assert property (@(posedge clock) disable iff (!resetn)
        $rose(boot_captured) && !$past(abs_encoder_present) |-> absolute_position_at_boot == 32'sh0)
        else $error("boot position nonzero without absolute encoder");

    chk_boot_ready: assert property (@(posedge clock) disable iff (!resetn)
        $rose(drive_ready) |-> $past(boot_ms) >= $past(boot_up_delay))
        else $error("drive ready before boot-up delay");

    chk_fb_absent: assert property (@(posedge clock) disable iff (!resetn)
        (fieldbus_active & ~fieldbus_availability) == 32'h00000000)
        else $error("absent fieldbus reported active");

    chk_fb_locked: assert property (@(posedge clock) disable iff (!resetn)
        ##1 ((fieldbus_active ^ $past(fieldbus_enable_control)) & fieldbus_disable_mask) == 32'h0)
        else $error("switchable fieldbus does not follow control");

endmodule : dcob_bank

`default_nettype wire

// ==== tb/dcob_host.sv ====
// Fieldbus host model issuing object accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module dcob_host (
    // Clock
    input wire logic clock,
    // Object access
    output var dcob_pkg::dcob_req_type req,
    input wire dcob_pkg::dcob_rsp_type rsp
);
    initial req = '0;
    // One strobe cycle per access; answer awaited under a bound of three edges
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic err, output logic [31:0] rd);
        err = 1'b1;
        rd = 32'h5a5aa5a5;
        @(posedge clock);
        req <= '{wr: wr, rd: !wr, index: idx, subindex: sub, wdata: wd};
        @(posedge clock);
        req <= '0;
        for (int i = 0; i < 3; i++) begin
            #1;
            if (rsp.valid === 1'b1) begin
                err = rsp.error;
                rd = rsp.rdata;
                break;
            end
            @(posedge clock);
        end
    endtask : xfer
endmodule : dcob_host
`default_nettype wire

// ==== tb/dcob_bank_tb.sv ====
// Self-checking bench for the drive object bank
`timescale 1ns/1ps
`default_nettype none
module dcob_bank_tb;
    // Short millisecond base keeps the slippage run brief
    localparam int MS = 10;
    localparam logic [31:0] AVAIL = 32'h001d0011;
    localparam logic [31:0] DMASK = 32'h00010011;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    dcob_pkg::dcob_req_type req;
    dcob_pkg::dcob_rsp_type rsp;
    logic vmode, reaction, step, dir, cw, ccw, present, slip, push, cwccw, single, ready;
    logic signed [31:0] act, cmd, abs_pos, scaled, mul, dv;
    logic [31:0] max_slip, active, v;
    int errors = 0;
    int n_checks = 0;
    int n;
    logic [15:0] idx_tab [9] = '{16'h203f, 16'h2057, 16'h2058, 16'h2059, 16'h205a,
                                 16'h205b, 16'h2084, 16'h2101, 16'h2102};
    logic [31:0] rst_tab [9] = '{32'h64, 32'h80, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
                                 AVAIL, AVAIL};

    dcob_bank #(.MS_CYCLES(MS), .FB_AVAILABLE(AVAIL), .FB_DISABLE_MASK(DMASK)) i_dut (
        .clock(clock), .resetn(resetn), .req(req), .rsp(rsp),
        .velocity_mode(vmode), .actual_speed(act), .commanded_speed(cmd),
        .max_slippage(max_slip), .slip_reaction_enabled(reaction),
        .statusword_slip(slip), .error_history_push(push), .step_pulse(step),
        .step_direction(dir), .cw_pulse(cw), .ccw_pulse(ccw), .scaled_pulse_count(scaled),
        .pulse_mode_cwccw(cwccw), .abs_encoder_present(present),
        .abs_encoder_position(abs_pos), .encoder_single_ended(single), .drive_ready(ready),
        .fieldbus_active(active));
    dcob_host i_host (.clock(clock), .req(req), .rsp(rsp));

    initial forever #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Expectations and checks
    function automatic logic [31:0] exp_active(input logic [31:0] ctl);
        return (AVAIL & ~DMASK) | (ctl & AVAIL & DMASK);
    endfunction : exp_active
    // Signed division truncates toward zero, as the bank does
    function automatic logic [31:0] exp_scaled(input int cnt, input int m, input int d);
        return (cnt * m) / d;
    endfunction : exp_scaled
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Access plus comparison; read data is only meaningful when not refused
    task automatic xchk(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, input logic eerr, input logic [31:0] erd);
        logic e;
        logic [31:0] d;
        i_host.xfer(wr, idx, sub, wd, e, d);
        check("refusal flag", 32'(e), 32'(eerr));
        if (!eerr) check("object data", d, wr ? 32'h0 : erd);
    endtask : xchk
    task automatic do_reset;
        resetn <= 1'b0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
    endtask : do_reset
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        {vmode, reaction, step, dir, cw, ccw, present} = '0;
        {act, cmd, abs_pos, max_slip} = '0;
        v = $urandom(96339);
        do_reset();
        for (int i = 0; i < 9; i++) xchk(0, idx_tab[i], 0, 0, 0, rst_tab[i]);
        xchk(0, 16'h2103, 0, 0, 0, 32'h2);
        xchk(0, 16'h2103, 1, 0, 0, DMASK);
        check("ready", 32'(ready), 32'h1);
        $display("test reset_values done");
        // Random write and readback of every writable object except the fieldbus control bitmap
        for (int i = 0; i < 7; i++) begin
            if (i == 4) continue;
            v = $urandom;
            xchk(1, idx_tab[i], 0, v, 0, 0);
            xchk(0, idx_tab[i], 0, 0, 0, i == 0 ? {16'h0, v[15:0]} : v);
            if (i == 3) check("encoder type", 32'(single), 32'(v[0]));
            if (i == 5) check("pulse mode", 32'(cwccw), 32'(v[0]));
        end
        // Writes to read-only and unknown objects and a bad subindex read are refused; a read-only read is not
        xchk(1, 16'h2101, 0, 32'h0, 1, 0);
        xchk(1, 16'h205a, 0, 32'hffffffff, 1, 0);
        xchk(1, 16'h2000, 0, 32'h1, 1, 0);
        xchk(0, 16'h2057, 1, 0, 1, 0);
        xchk(0, 16'h2101, 0, 0, 0, AVAIL);
        $display("test access done");
        // Only switchable and present buses follow the control bitmap
        foreach (rst_tab[i]) if (i < 2) begin
            v = i ? 32'hffffffff : 32'h0;
            xchk(1, 16'h2102, 0, v, 0, 0);
            xchk(0, 16'h2102, 0, 0, 0, v);
            check("active set", active, exp_active(v));
            xchk(0, 16'h2103, 2, 0, 0, exp_active(v));
        end
        $display("test fieldbus done");
        // Boot capture and step/direction scaling after a fresh reset
        present <= 1'b1;
        abs_pos <= $urandom;
        do_reset();
        xchk(0, 16'h205a, 0, 0, 0, abs_pos);
        mul = $urandom_range(600) - 300;
        dv = $urandom_range(1, 9) * ($urandom_range(1) ? -1 : 1);
        n = $urandom_range(1, 20);
        xchk(1, 16'h2057, 0, mul, 0, 0);
        xchk(1, 16'h2058, 0, dv, 0, 0);
        dir <= 1'($urandom_range(1));
        repeat (n) begin
            @(posedge clock) step <= 1'b1;
            @(posedge clock) step <= 1'b0;
        end
        repeat (4) @(posedge clock);
        #1 check("scaled count", scaled, exp_scaled(dir ? -n : n, mul, dv));
        // The cw/ccw mode counts cw edges up and ccw edges down
        xchk(1, 16'h205b, 0, 32'h1, 0, 0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock) {cw, ccw} <= (k < 3) ? 2'b10 : 2'b01;
            @(posedge clock) {cw, ccw} <= 2'b00;
        end
        repeat (4) @(posedge clock);
        #1 check("cw ccw count", scaled, exp_scaled((dir ? -n : n) + 2, mul, dv));
        $display("test pulses done");
        // Slippage must outlast two milliseconds before the flag rises
        xchk(1, 16'h203f, 0, 32'h2, 0, 0);
        @(posedge clock);
        {vmode, reaction} <= 2'b11;
        act <= 32'sd1000;
        cmd <= -32'sd5;
        max_slip <= 32'd10;
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (slip !== 1'b1 && n < 80);
        check("slip not early", 32'(n > 2 * MS), 32'h1);
        check("slip in time", 32'(n <= 4 * MS + 5), 32'h1);
        check("history push", 32'(push), 32'h1);
        @(posedge clock) act <= 32'sd0;
        repeat (3) @(posedge clock);
        #1 check("slip cleared", 32'(slip), 32'h0);
        $display("test slippage done");
        final_report();
    end
endmodule : dcob_bank_tb
`default_nettype wire
